// ---- battery_fault_protect_fsm.v ----
// The AHB-Lite register port and the placing of the registers were left to the implementer.
`timescale 1ns/1ps
`default_nettype none
`include "fault_protect_regs.vh"
// What this block does
// RULE_01: Cell over threshold past its delay turns charge FET off, alert low.
// RULE_02: Host mode overvoltage recovery needs all cells below threshold, no hysteresis.
// RULE_03: Host mode charge FET returns only after the host command sequence.
// RULE_04: Host pulses latch clear, then writes charge FET bit to one.
// RULE_05: Alert returns high only on a status read after recovery writes.
// RULE_06: Stand-alone overvoltage recovers once cells are below threshold minus hysteresis.
// RULE_07: Cell under threshold past its delay turns discharge FET off, alert low.
// RULE_08: Host undervoltage recovery: above threshold plus hysteresis, or above threshold with charger.
// RULE_09: Charger present when pack-above-battery comparator reports it.
// RULE_10: With auto-off disabled, undervoltage only lowers alert, discharge FET stays; the code still shuts down stand-alone without a charger.
// RULE_11: Host undervoltage recovery: clear pulse, discharge FET bit, then status read.
// RULE_12: Stand-alone undervoltage entry moves the device to shutdown.
// RULE_13: Charger wakes from shutdown; no shutdown while charger attached.
// RULE_14: Stand-alone undervoltage recovery restores discharge FET and alert automatically.
// RULE_15: Overcurrent past its blanking delay turns both FETs off.
// RULE_16: Short circuit past its blanking delay turns both FETs off.
// RULE_17: Host current fault recovery: clear pulse, both FET bits, status read.
// RULE_18: Stand-alone, auto-recover off: after 12.8 s, a charger restores both FETs.
// RULE_19: Stand-alone, auto-recover on: both FETs restored 12.8 s after the fault.
// RULE_20: Current fault delays come from the configuration registers, not constants.
// RULE_21: Stand-alone mode ignores host FET control bits.
// RULE_22: Zero-delay select forces all detection delays to zero.
// RULE_23: FETs held off until regulator power is valid.
// RULE_24: Mode input picks recovery behaviour only, sampled continuously; the code also uses it to gate undervoltage shutdown and the host FET bits.
// RULE_25: Each fault sets a status flag held until latch clear.
module battery_fault_protect_fsm #(
    parameter [31:0] RECOVER_CYCLES = `RECOVER_CYCLES
) (
    input wire clk_sys_in,
    input wire nrst_in,
    input wire clk_en_in,
    input wire [31:0] haddr,
    input wire [1:0] htrans,
    input wire hwrite,
    input wire [2:0] hsize,
    input wire hsel,
    input wire hready,
    input wire [31:0] hwdata,
    output reg [31:0] hrdata,
    output reg hreadyout,
    output reg hresp,
    input wire host_mode_in,
    input wire zero_delay_select_in,
    input wire reg_power_good_in,
    input wire cell_over_in,
    input wire cell_below_ov_hyst_in,
    input wire cell_under_in,
    input wire cell_above_uv_hyst_in,
    input wire discharge_overcurrent_in,
    input wire discharge_short_circuit_in,
    input wire charger_detect_in,
    output reg charge_fet_on_out,
    output reg discharge_fet_on_out,
    output reg fault_alert_out_n,
    output reg shutdown_out
);
    // ----------------------------------------------------------------
    // Recovery state per fault; overcurrent and short circuit share one
    // ----------------------------------------------------------------
    localparam [1:0] ST_OK = 2'h0;
    localparam [1:0] ST_FAULT = 2'h1;
    localparam [1:0] ST_WAIT = 2'h2;

    reg [1:0] ov_st_r;
    reg [1:0] uv_st_r;
    reg [1:0] cf_st_r;
    reg [31:0] rec_cnt_r;
    reg [3:0] flags_r;
    reg [1:0] cfg_r;
    reg [`DELAY_W-1:0] dly_r [0:3];
    reg host_chg_r;
    reg host_dsg_r;
    reg clr_r;
    reg cleared_r;
    reg written_r;
    reg alert_n_r;
    reg wr_pend_r;
    reg rd_pend_r;
    reg [7:0] addr_r;
    wire [3:0] fire;
    wire [3:0] cond;
    wire take;
    wire any_fault;
    wire charger;
    wire ov_rec;
    wire uv_rec;
    reg chg_nxt;
    reg dsg_nxt;
    integer i;

    assign charger = charger_detect_in; // RULE_09
    assign cond = {discharge_short_circuit_in, discharge_overcurrent_in,
                   cell_under_in, cell_over_in};
    assign take = hsel && hready && htrans[1];
    assign any_fault = (ov_st_r != ST_OK) || (uv_st_r != ST_OK) || (cf_st_r != ST_OK);
    // Overvoltage: host mode ignores hysteresis, stand-alone requires it; undervoltage recovery is the same in both modes.
    assign ov_rec = host_mode_in ? !cell_over_in : cell_below_ov_hyst_in; // RULE_02 RULE_06
    assign uv_rec = cell_above_uv_hyst_in || (!cell_under_in && charger); // RULE_08

    // Register address to delay index decode for the four fault types.
    function [1:0] dly_index;
        input [7:0] a;
        begin
            dly_index = a[3:2] - 2'h3;
        end
    endfunction

    // ----------------------------------------------------------------
    // Detection timers
    // ----------------------------------------------------------------
    genvar g;
    generate
        for (g = 0; g < 4; g = g + 1) begin : det
            fault_delay_timer u_tmr (
                .clk_sys_in(clk_sys_in),
                .nrst_in(nrst_in),
                .en_in(clk_en_in),
                .cond_in(cond[g]),
                .zero_delay_in(zero_delay_select_in), // RULE_22
                .limit_in(dly_r[g]), // RULE_20
                .fire_out(fire[g])
            );
        end
    endgenerate

    // ----------------------------------------------------------------
    // AHB-Lite slave, zero wait states, always OKAY
    // ----------------------------------------------------------------
    // Writes land in the data phase; reads are answered from live state.
    always @(posedge clk_sys_in or negedge nrst_in) begin
        if (!nrst_in) begin
            wr_pend_r <= 1'b0;
            rd_pend_r <= 1'b0;
            addr_r <= 8'h00;
            hrdata <= 32'h00000000;
            hreadyout <= 1'b1;
            hresp <= 1'b0;
            cfg_r <= `CFG_RESET;
            host_chg_r <= 1'b0;
            host_dsg_r <= 1'b0;
            clr_r <= 1'b0;
            for (i = 0; i < 4; i = i + 1) begin
                dly_r[i] <= `DELAY_RESET;
            end
        end else if (clk_en_in) begin
            wr_pend_r <= take && hwrite;
            rd_pend_r <= take && !hwrite;
            if (take) begin
                addr_r <= haddr[7:0];
            end
            if (wr_pend_r) begin
                case (addr_r)
                    `REG_CONTROL: begin
                        clr_r <= hwdata[`CTL_LATCH_CLEAR];
                        host_chg_r <= hwdata[`CTL_CHARGE_FET_ON];
                        host_dsg_r <= hwdata[`CTL_DISCHARGE_FET_ON];
                    end
                    `REG_CONFIG: cfg_r <= hwdata[1:0];
                    `REG_DELAY_OV, `REG_DELAY_UV, `REG_DELAY_OC, `REG_DELAY_SC: begin
                        dly_r[dly_index(addr_r)] <= hwdata; // RULE_20
                    end
                    default: ;
                endcase
            end
            // Read data is prepared in the address phase so it stands in the data phase.
            if (take && !hwrite) begin
                case (haddr[7:0])
                    `REG_CONTROL: hrdata <= {29'h0, host_dsg_r, host_chg_r, clr_r};
                    `REG_STATUS: hrdata <= {25'h0, charger, shutdown_out,
                                            !fault_alert_out_n, flags_r};
                    `REG_CONFIG: hrdata <= {30'h0, cfg_r};
                    `REG_DELAY_OV, `REG_DELAY_UV, `REG_DELAY_OC, `REG_DELAY_SC: begin
                        hrdata <= dly_r[dly_index(haddr[7:0])];
                    end
                    `REG_FETS: hrdata <= {30'h0, discharge_fet_on_out, charge_fet_on_out};
                    default: hrdata <= 32'h00000000;
                endcase
            end
        end
    end

    // ----------------------------------------------------------------
    // Fault state machines and host recovery sequence
    // ----------------------------------------------------------------
    // Detection is identical in both modes; the mode input steers recovery and whether undervoltage entry shuts down.
    always @(posedge clk_sys_in or negedge nrst_in) begin
        if (!nrst_in) begin
            ov_st_r <= ST_OK;
            uv_st_r <= ST_OK;
            cf_st_r <= ST_OK;
            rec_cnt_r <= 32'h00000000;
            flags_r <= 4'h0;
            cleared_r <= 1'b0;
            written_r <= 1'b0;
            alert_n_r <= 1'b1;
            shutdown_out <= 1'b0;
        end else if (clk_en_in) begin
            // A fresh fault wins over a clear in the same cycle.
            if (wr_pend_r && addr_r == `REG_CONTROL && clr_r && !hwdata[`CTL_LATCH_CLEAR]) begin
                flags_r <= fire; // RULE_25
                cleared_r <= any_fault; // RULE_04
            end else begin
                flags_r <= flags_r | fire; // RULE_25
            end
            if (cleared_r && wr_pend_r && addr_r == `REG_CONTROL) begin
                written_r <= 1'b1;
            end
            if (fire[0]) begin
                ov_st_r <= ST_FAULT; // RULE_01
                alert_n_r <= 1'b0;
            end
            if (fire[1]) begin
                uv_st_r <= ST_FAULT; // RULE_07
                alert_n_r <= 1'b0;
                shutdown_out <= !host_mode_in && !charger; // RULE_12 RULE_13
            end
            if (fire[2] || fire[3]) begin
                cf_st_r <= ST_FAULT; // RULE_15 RULE_16
                rec_cnt_r <= 32'h00000000;
                alert_n_r <= 1'b0;
            end
            if (charger) begin
                shutdown_out <= 1'b0; // RULE_13
            end
            if (!host_mode_in) begin // RULE_24
                if (ov_st_r == ST_FAULT && ov_rec && !fire[0]) begin
                    ov_st_r <= ST_OK; // RULE_06
                end
                if (uv_st_r == ST_FAULT && uv_rec && !fire[1]) begin
                    uv_st_r <= ST_OK; // RULE_14
                end
                case (cf_st_r)
                    ST_FAULT: begin
                        if (rec_cnt_r >= RECOVER_CYCLES - 32'h1) begin
                            cf_st_r <= ST_WAIT;
                        end else begin
                            rec_cnt_r <= rec_cnt_r + 32'h1;
                        end
                    end
                    ST_WAIT: begin
                        if (cfg_r[`CFG_CURRENT_FAULT_AUTO_RECOVER] || charger) begin
                            cf_st_r <= ST_OK; // RULE_18 RULE_19
                        end
                    end
                    default: ;
                endcase
                // Alert follows live state, so a fire that lasts one cycle still drops it.
                alert_n_r <= !any_fault && !(|fire); // RULE_14
                cleared_r <= 1'b0;
                written_r <= 1'b0;
            end else begin
                // Host path: latch clear, FET write, then a status read releases current faults, and OV/UV faults whose recovery condition holds.
                if (written_r && rd_pend_r && addr_r == `REG_STATUS && !(|fire)) begin // RULE_05
                    if (ov_st_r != ST_OK && ov_rec) begin
                        ov_st_r <= ST_OK; // RULE_03
                    end
                    if (uv_st_r != ST_OK && uv_rec) begin
                        uv_st_r <= ST_OK; // RULE_11
                    end
                    if (cf_st_r != ST_OK) begin
                        cf_st_r <= ST_OK; // RULE_17
                    end
                    alert_n_r <= 1'b1; // RULE_05
                    cleared_r <= 1'b0;
                    written_r <= 1'b0;
                end
            end
        end
    end

    // ----------------------------------------------------------------
    // FET drive decision
    // ----------------------------------------------------------------
    // In host mode the FET bits only matter once the device has released the fault.
    always @* begin
        chg_nxt = (ov_st_r == ST_OK) && (cf_st_r == ST_OK);
        dsg_nxt = (cf_st_r == ST_OK) &&
                  ((uv_st_r == ST_OK) || cfg_r[`CFG_UV_FET_AUTO_OFF_DISABLE]); // RULE_10
        if (host_mode_in) begin
            chg_nxt = chg_nxt && host_chg_r;
            dsg_nxt = dsg_nxt && host_dsg_r;
        end // RULE_21
        if (shutdown_out || !reg_power_good_in) begin
            chg_nxt = 1'b0; // RULE_23
            dsg_nxt = 1'b0;
        end
    end

    // Registered outputs keep the pins glitch-free.
    always @(posedge clk_sys_in or negedge nrst_in) begin
        if (!nrst_in) begin
            charge_fet_on_out <= 1'b0;
            discharge_fet_on_out <= 1'b0;
            fault_alert_out_n <= 1'b1;
        end else if (clk_en_in) begin
            charge_fet_on_out <= chg_nxt;
            discharge_fet_on_out <= dsg_nxt;
            fault_alert_out_n <= alert_n_r;
        end
    end
endmodule
`default_nettype wire

// ---- fault_delay_timer.v ----
`timescale 1ns/1ps
`default_nettype none
`include "fault_protect_regs.vh"
// Counts how long a condition has held; fires once the programmed count passes.
module fault_delay_timer (
    input wire clk_sys_in,
    input wire nrst_in,
    input wire en_in,
    input wire cond_in,
    input wire zero_delay_in,
    input wire [`DELAY_W-1:0] limit_in,
    output reg fire_out
);
    reg [`DELAY_W-1:0] cnt_r;

    // ----------------------------------------------------------------
    // Persistence counter
    // ----------------------------------------------------------------
    // A dropped condition restarts the count so short glitches never trip.
    always @(posedge clk_sys_in or negedge nrst_in) begin
        if (!nrst_in) begin
            cnt_r <= {`DELAY_W{1'b0}};
            fire_out <= 1'b0;
        end else if (en_in) begin
            if (!cond_in) begin
                cnt_r <= {`DELAY_W{1'b0}};
                fire_out <= 1'b0;
            end else if (zero_delay_in || cnt_r >= limit_in) begin
                fire_out <= 1'b1; // RULE_22
            end else begin
                cnt_r <= cnt_r + {{(`DELAY_W-1){1'b0}}, 1'b1};
                fire_out <= 1'b0;
            end
        end
    end
endmodule
`default_nettype wire

// ---- fault_protect_regs.vh ----
`ifndef FAULT_PROTECT_REGS_VH
`define FAULT_PROTECT_REGS_VH
// ----------------------------------------------------------------
// Register offsets (byte addresses, one word each)
// ----------------------------------------------------------------
`define REG_CONTROL 8'h00
`define REG_STATUS 8'h04
`define REG_CONFIG 8'h08
`define REG_DELAY_OV 8'h0C
`define REG_DELAY_UV 8'h10
`define REG_DELAY_OC 8'h14
`define REG_DELAY_SC 8'h18
`define REG_FETS 8'h1C
// ----------------------------------------------------------------
// Control register fields
// ----------------------------------------------------------------
`define CTL_LATCH_CLEAR 0
`define CTL_CHARGE_FET_ON 1
`define CTL_DISCHARGE_FET_ON 2
// ----------------------------------------------------------------
// Config register fields
// ----------------------------------------------------------------
`define CFG_UV_FET_AUTO_OFF_DISABLE 0
`define CFG_CURRENT_FAULT_AUTO_RECOVER 1
`define CFG_RESET 2'h0
// ----------------------------------------------------------------
// Status register fields
// ----------------------------------------------------------------
`define ST_OV 0
`define ST_UV 1
`define ST_OC 2
`define ST_SC 3
`define ST_ALERT 4
`define ST_SHUTDOWN 5
`define ST_CHARGER 6
// ----------------------------------------------------------------
// Timing and reset values
// ----------------------------------------------------------------
`define DELAY_W 32
`define DELAY_RESET 32'h00000001
`define RECOVER_TIME_MS 12800
`define CLK_KHZ 250000
`define RECOVER_CYCLES 32'hBEBC2000
`endif

// ---- fault_protect_sva.sv ----
`timescale 1ns/1ps
`default_nettype none
`include "fault_protect_regs.vh"
// ----------------------------------------
// Protection checker
// ----------------------------------------
module fault_protect_sva #(
    parameter [31:0] RECOVER_CYCLES = `RECOVER_CYCLES
) (
    input wire logic clk_sys_in,
    input wire logic nrst_in,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic hsel,
    input wire logic host_mode_in,
    input wire logic zero_delay_select_in,
    input wire logic reg_power_good_in,
    input wire logic cell_over_in,
    input wire logic cell_under_in,
    input wire logic discharge_overcurrent_in,
    input wire logic discharge_short_circuit_in,
    input wire logic charge_fet_on_out,
    input wire logic discharge_fet_on_out,
    input wire logic fault_alert_out_n,
    input wire logic shutdown_out
);
    localparam logic [31:0] CTL_A = {24'h000000, `REG_CONTROL};
    localparam logic [31:0] ST_A = {24'h000000, `REG_STATUS};
    logic [3:0] since_ctl_r;
    logic [3:0] since_rd_r;
    wire logic take = hsel && htrans[1];
    default clocking cb @(posedge clk_sys_in);
    endclocking
    default disable iff (!nrst_in);
    // Ages since the host last touched control or status; saturating keeps them narrow.
    always @(posedge clk_sys_in or negedge nrst_in) begin
        if (!nrst_in) begin
            since_ctl_r <= 4'hF;
            since_rd_r <= 4'hF;
        end else begin
            if (take && (haddr == CTL_A || haddr == ST_A)) since_ctl_r <= 4'h0;
            else if (since_ctl_r != 4'hF) since_ctl_r <= since_ctl_r + 4'h1;
            if (take && !hwrite && haddr == ST_A) since_rd_r <= 4'h0;
            else if (since_rd_r != 4'hF) since_rd_r <= since_rd_r + 4'h1;
        end
    end
    a_power_fets_off: assert property (
        !reg_power_good_in [*2] |-> !charge_fet_on_out && !discharge_fet_on_out)
        else $error("FET on without regulator power");
    a_shutdown_fets_off: assert property (
        shutdown_out [*2] |-> !charge_fet_on_out && !discharge_fet_on_out)
        else $error("FET on during shutdown");
    a_ov_charge_off: assert property (
        zero_delay_select_in && cell_over_in |-> ##[1:3] !charge_fet_on_out)
        else $error("charge FET kept on in overvoltage");
    a_uv_alert_low: assert property (
        zero_delay_select_in && cell_under_in |-> ##[1:3] !fault_alert_out_n)
        else $error("alert not raised in undervoltage");
    a_oc_fets_off: assert property (
        zero_delay_select_in && discharge_overcurrent_in
        |-> ##[1:3] !charge_fet_on_out && !discharge_fet_on_out)
        else $error("FET kept on in overcurrent");
    a_sc_fets_off: assert property (
        zero_delay_select_in && discharge_short_circuit_in
        |-> ##[1:3] !charge_fet_on_out && !discharge_fet_on_out)
        else $error("FET kept on in short circuit");
    a_host_charge_hold: assert property (
        host_mode_in && $rose(charge_fet_on_out) |-> since_ctl_r < 4'h8)
        else $error("charge FET restored without host access");
    a_host_alert_hold: assert property (
        host_mode_in && $rose(fault_alert_out_n) |-> since_rd_r < 4'h8)
        else $error("alert released without status read");
endmodule
bind battery_fault_protect_fsm fault_protect_sva #(.RECOVER_CYCLES(RECOVER_CYCLES)) sva_i (
    .clk_sys_in, .nrst_in, .haddr, .htrans, .hwrite, .hsel, .host_mode_in,
    .zero_delay_select_in, .reg_power_good_in, .cell_over_in, .cell_under_in,
    .discharge_overcurrent_in, .discharge_short_circuit_in, .charge_fet_on_out,
    .discharge_fet_on_out, .fault_alert_out_n, .shutdown_out);
`default_nettype wire

// ---- host_model.sv ----
`timescale 1ns/1ps
`default_nettype none
`include "fault_protect_regs.vh"
// ----------------------------------------
// Host controller model, bus master
// ----------------------------------------
module host_model (
    input wire logic clk_sys_in,
    input wire logic hready,
    input wire logic [31:0] hrdata,
    output logic [31:0] haddr,
    output logic [1:0] htrans,
    output logic hwrite,
    output logic [2:0] hsize,
    output logic hsel,
    output logic [31:0] hwdata
);
    // Idle bus at time zero; only whole words are ever moved.
    initial begin
        {haddr, htrans, hwrite, hsel} = 36'h0;
        hsize = 3'h2;
        hwdata = 32'hFFFFFFFF;
    end
    // One single transfer; each phase is held until hready is seen high.
    task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d,
                        output logic [31:0] q);
        @(posedge clk_sys_in);
        haddr <= {24'h000000, a};
        {htrans, hwrite, hsel} <= {2'h2, w, 1'b1};
        @(posedge clk_sys_in);
        while (hready !== 1'b1) @(posedge clk_sys_in);
        {htrans, hsel} <= 3'h0;
        hwdata <= d;
        @(posedge clk_sys_in);
        while (hready !== 1'b1) @(posedge clk_sys_in);
        q = hrdata;
        // Released data lines flip so a stale word is never mistaken for a fresh one.
        hwdata <= ~d;
    endtask
    // Clear pulse first, FET bits after; the status read is left to the caller.
    task automatic recover(input logic [2:0] fets);
        logic [31:0] q;
        xfer(1'b1, `REG_CONTROL, 32'h1 | {29'h0, fets}, q);
        xfer(1'b1, `REG_CONTROL, {29'h0, fets}, q);
        xfer(1'b1, `REG_CONTROL, {29'h0, fets}, q);
    endtask
endmodule
`default_nettype wire

// ---- tb.sv ----
`timescale 1ns/1ps
`default_nettype none
`include "fault_protect_regs.vh"
module tb;
    localparam int REC = 20;
    logic clk_sys_in, nrst_in, host_mode_in, zero_delay_select_in, reg_power_good_in;
    logic cell_over_in, cell_below_ov_hyst_in, cell_under_in, cell_above_uv_hyst_in;
    logic oc_in, sc_in, charger_in, hwrite, hsel, hreadyout, hresp, charge_fet_on, discharge_fet_on, alert_n, shdn;
    logic [31:0] haddr, hwdata, hrdata, q;
    logic [1:0] htrans;
    logic [2:0] hsize;
    int errors = 0;
    int cmp_count = 0;
    // ----------------------------------------
    // Clock, design and host
    // ----------------------------------------
    initial begin
        clk_sys_in = 1'b0;
        forever #2 clk_sys_in = ~clk_sys_in;
    end
    battery_fault_protect_fsm #(.RECOVER_CYCLES(REC)) uut (
        .clk_sys_in, .nrst_in, .clk_en_in(1'b1), .haddr, .htrans, .hwrite, .hsize, .hsel,
        .hready(hreadyout), .hwdata, .hrdata, .hreadyout, .hresp, .host_mode_in,
        .zero_delay_select_in, .reg_power_good_in, .cell_over_in, .cell_below_ov_hyst_in,
        .cell_under_in, .cell_above_uv_hyst_in, .discharge_overcurrent_in(oc_in),
        .discharge_short_circuit_in(sc_in), .charger_detect_in(charger_in),
        .charge_fet_on_out(charge_fet_on), .discharge_fet_on_out(discharge_fet_on), .fault_alert_out_n(alert_n),
        .shutdown_out(shdn));
    host_model host (.clk_sys_in, .hready(hreadyout), .hrdata, .haddr, .htrans, .hwrite,
        .hsize, .hsel, .hwdata);
    // Shared helpers; pin checks wait for the falling edge so outputs have settled.
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        cmp_count++;
        if (got !== exp) begin
            errors++;
            $display("mismatch at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic cyc(input int n);
        repeat (n) @(posedge clk_sys_in);
    endtask
    task automatic fets(input logic [2:0] e);
        @(negedge clk_sys_in);
        chk({29'h0, charge_fet_on, discharge_fet_on, alert_n}, {29'h0, e});
    endtask
    task automatic rd(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e);
        host.xfer(1'b0, a, 32'h0, q);
        chk(q & m, e);
        chk({31'h0, hresp}, 32'h0);
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        host.xfer(1'b1, a, d, q);
    endtask
    task automatic final_report();
        $display("errors %0d comparisons %0d", errors, cmp_count);
        if (errors == 0 && cmp_count > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask
    // ----------------------------------------
    // Scenarios
    // ----------------------------------------
    task automatic s_reset();
        fets(3'b001);
        cyc(20);
        nrst_in <= 1'b1;
        cyc(3);
        fets(3'b111);
        rd(`REG_CONFIG, 32'hFFFFFFFF, {30'h0, `CFG_RESET});
        wr(8'h40, 32'hFFFFFFFF);
        rd(8'h40, 32'hFFFFFFFF, 32'h0);
        for (int i = 0; i < 4; i++) begin
            rd(`REG_DELAY_OV + 8'(4 * i), 32'hFFFFFFFF, `DELAY_RESET);
            wr(`REG_DELAY_OV + 8'(4 * i), 32'h5);
            rd(`REG_DELAY_OV + 8'(4 * i), 32'hFFFFFFFF, 32'h5);
        end
        cyc(1);
        reg_power_good_in <= 1'b0;
        cyc(2);
        fets(3'b001);
        cyc(1);
        reg_power_good_in <= 1'b1;
    endtask
    // A programmed count of five must neither fire early nor late.
    task automatic s_sa_ov();
        wr(`REG_CONTROL, 32'h0);
        {cell_over_in, cell_below_ov_hyst_in} <= 2'b10;
        cyc(5);
        fets(3'b111);
        cyc(5);
        fets(3'b010);
        rd(`REG_STATUS, 32'h7F, 32'h11);
        cell_over_in <= 1'b0;
        cyc(8);
        fets(3'b010);
        cyc(1);
        cell_below_ov_hyst_in <= 1'b1;
        cyc(4);
        fets(3'b111);
    endtask
    // Zero-delay stays on for the stand-alone scenarios that follow, to keep them short.
    task automatic s_zero();
        cyc(1);
        {zero_delay_select_in, cell_over_in, cell_below_ov_hyst_in} <= 3'b110;
        cyc(1);
        cell_over_in <= 1'b0;
        cyc(2);
        fets(3'b010);
        cyc(1);
        cell_below_ov_hyst_in <= 1'b1;
        cyc(4);
        fets(3'b111);
    endtask
    task automatic s_sa_uv();
        cyc(1);
        {cell_under_in, cell_above_uv_hyst_in} <= 2'b10;
        cyc(4);
        fets(3'b000);
        chk(shdn, 1'b1);
        cyc(1);
        charger_in <= 1'b1;
        cyc(4);
        fets(3'b100);
        chk(shdn, 1'b0);
        cyc(1);
        cell_under_in <= 1'b0;
        cyc(4);
        fets(3'b111);
        cyc(1);
        {charger_in, cell_above_uv_hyst_in} <= 2'b01;
    endtask
    task automatic s_sa_cur();
        wr(`REG_CONFIG, 32'h2);
        oc_in <= 1'b1;
        cyc(4);
        fets(3'b000);
        cyc(1);
        oc_in <= 1'b0;
        cyc(8);
        fets(3'b000);
        cyc(REC);
        fets(3'b111);
        wr(`REG_CONFIG, 32'h0);
        sc_in <= 1'b1;
        cyc(4);
        fets(3'b000);
        cyc(1);
        sc_in <= 1'b0;
        cyc(REC + 8);
        fets(3'b000);
        cyc(1);
        charger_in <= 1'b1;
        cyc(4);
        fets(3'b111);
        cyc(1);
        {charger_in, zero_delay_select_in, host_mode_in} <= 3'b001;
    endtask
    // The hysteresis input stays low: host recovery must not wait for it.
    task automatic s_host_ov();
        wr(`REG_CONTROL, 32'h6);
        {cell_over_in, cell_below_ov_hyst_in} <= 2'b10;
        cyc(12);
        fets(3'b010);
        cyc(1);
        cell_over_in <= 1'b0;
        cyc(10);
        fets(3'b010);
        rd(`REG_STATUS, 32'h1, 32'h1);
        host.recover(3'b110);
        fets(3'b010);
        rd(`REG_STATUS, 32'h1, 32'h0);
        cyc(4);
        fets(3'b111);
        cyc(1);
        cell_below_ov_hyst_in <= 1'b1;
    endtask
    task automatic s_host_uv();
        wr(`REG_CONFIG, 32'h1);
        {cell_under_in, cell_above_uv_hyst_in} <= 2'b10;
        cyc(12);
        fets(3'b110);
        cyc(1);
        {cell_under_in, cell_above_uv_hyst_in} <= 2'b01;
        host.recover(3'b110);
        rd(`REG_STATUS, 32'h2, 32'h0);
        cyc(4);
        fets(3'b111);
        wr(`REG_CONFIG, 32'h0);
    endtask
    task automatic s_host_cur();
        for (int i = 0; i < 2; i++) begin
            cyc(1);
            {oc_in, sc_in} <= (i == 0) ? 2'b10 : 2'b01;
            cyc(12);
            fets(3'b000);
            cyc(1);
            {oc_in, sc_in} <= 2'b00;
            cyc(REC + 8);
            fets(3'b000);
            host.recover(3'b110);
            rd(`REG_STATUS, 32'hC, 32'h0);
            cyc(4);
            fets(3'b111);
        end
    endtask
    // Main sequence; all inputs get a value at time zero.
    initial begin
        nrst_in = 1'b0;
        {host_mode_in, zero_delay_select_in, charger_in, cell_over_in} = 4'h0;
        {cell_under_in, oc_in, sc_in} = 3'h0;
        {reg_power_good_in, cell_below_ov_hyst_in, cell_above_uv_hyst_in} = 3'h7;
        s_reset();
        s_sa_ov();
        s_zero();
        s_sa_uv();
        s_sa_cur();
        s_host_ov();
        s_host_uv();
        s_host_cur();
        final_report();
    end
    // The full run needs well under a thousand cycles, so this only trips on a hang.
    initial begin
        cyc(5000);
        errors++;
        final_report();
    end
endmodule
`default_nettype wire
